// file: cam_pkg.sv
// package for the content-addressable memory block
// assumes a single clock; users import the whole package
package cam_pkg;

    // geometry defaults
    localparam int CAM_WORDS = 32;
    localparam int CAM_WIDTH = 32;
    localparam int CAM_LINES = 16;
    localparam int CAM_AW    = 5;

    // reset values of the stored contents
    localparam logic [CAM_WIDTH-1:0] CAM_DATA_RST = 32'h0000_0000;
    localparam logic [CAM_WIDTH-1:0] CAM_CARE_ALL = 32'hFFFF_FFFF;

    // result-half codes of the one-hot form
    localparam logic CAM_HALF_LO = 1'h0;
    localparam logic CAM_HALF_HI = 1'h1;

    // write sequencer states
    typedef enum logic [2:0] {
        CAM_W_IDLE = 3'h1,
        CAM_W_DATA = 3'h2,
        CAM_W_MASK = 3'h4
    } cam_wst_t;

endpackage : cam_pkg

// file: cam_core.sv
// content-addressable memory: 32 entries of 32 bits with per-bit mask
// assumes synchronous user inputs on one clock; clears are asynchronous

// Notes on behaviour
// - thirty-two entries of thirty-two bits, all compared on every search
// - search word compared against every entry at once, location returned
// - match flag high whenever at least one entry matches the search
// - bits written as don't-care never cause or prevent a match
// - encoded form puts the binary index of the match on the result lines
// - one-hot form raises the result line of each matching entry
// - one-hot result for 32 entries comes in two cycles, 16 each
// - write inputs registered; optional output stage adds one pipeline cycle
// - all registers clear asynchronously from local, global or chip reset
// - plain write takes two cycles, write with don't-care bits takes three
// - contents start from configured values or are written in operation
module cam_core
    import cam_pkg::*;
#(
    parameter int                             WORDS     = CAM_WORDS,
    parameter int                             WIDTH     = CAM_WIDTH,
    parameter int                             LINES     = CAM_LINES,
    parameter int                             AW        = CAM_AW,
    parameter bit                             OUT_REG   = 1'b0,
    parameter logic [WORDS-1:0][WIDTH-1:0]    INIT_DATA = '0,
    parameter logic [WORDS-1:0][WIDTH-1:0]    INIT_CARE = '1
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clr_local,
    input  wire logic              clr_global,
    input  wire logic              clr_chip,
    input  wire logic              enc_sel,
    input  wire logic              srch_valid,
    input  wire logic [WIDTH-1:0]  srch_word,
    input  wire logic              wr_en,
    input  wire logic [AW-1:0]     wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic [WIDTH-1:0]  wr_care,
    input  wire logic              wr_use_mask,
    output logic                   srch_busy,
    output logic                   wr_busy,
    output logic                   res_valid,
    output logic                   res_match,
    output logic                   res_half,
    output logic [LINES-1:0]       res_lines
);

    typedef struct packed {
        logic [WORDS-1:0][WIDTH-1:0] mem_data;
        logic [WORDS-1:0][WIDTH-1:0] mem_care;
        cam_wst_t                    wst;
        logic [AW-1:0]               w_addr;
        logic [WIDTH-1:0]            w_data;
        logic [WIDTH-1:0]            w_care;
        logic                        w_mask;
        logic                        w_busy;
        logic                        in_v;
        logic [WIDTH-1:0]            in_word;
        logic                        s_busy;
        logic                        hi_pend;
        logic [LINES-1:0]            hi_vec;
        logic                        hi_match;
        logic                        o1_v;
        logic                        o1_match;
        logic                        o1_half;
        logic [LINES-1:0]            o1_lines;
        logic                        o2_v;
        logic                        o2_match;
        logic                        o2_half;
        logic [LINES-1:0]            o2_lines;
    } cam_st_t;

    cam_st_t          s_r;
    cam_st_t          s_nxt;
    logic             clr_any;
    logic [WORDS-1:0] hit;
    logic [AW-1:0]    hit_idx;
    logic             any_hit;

    // reset image: configured contents, idle pipeline
    function automatic cam_st_t cam_rst_val();
        cam_st_t v;
        v          = '0;
        v.mem_data = INIT_DATA;
        v.mem_care = INIT_CARE;
        v.wst      = CAM_W_IDLE;
        return v;
    endfunction
    localparam cam_st_t CAM_RST_IMG = cam_rst_val();

    // local, global and chip clears reach every register
    assign clr_any = clr_local | clr_global | clr_chip;
    assign any_hit = |hit;

    // parallel compare of every entry
    always_comb begin
        hit     = '0;
        hit_idx = '0;
        for (int i = 0; i < WORDS; i++) begin
            // a cleared care bit takes that bit out of the compare
            hit[i] = ~|((s_r.in_word ^ s_r.mem_data[i])
                        & s_r.mem_care[i]);
        end
        // lowest matching index wins in encoded form
        for (int i = WORDS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = AW'(i);
            end
        end
    end

    always_comb begin
        s_nxt      = s_r;
        // result pulses last one cycle unless refilled
        s_nxt.o1_v = 1'b0;

        // write sequencer
        case (s_r.wst)
            CAM_W_IDLE: begin
                // a request while busy is never looked at
                if (wr_en) begin
                    s_nxt.w_addr = wr_addr;
                    s_nxt.w_data = wr_data;
                    s_nxt.w_care = wr_care;
                    s_nxt.w_mask = wr_use_mask;
                    s_nxt.wst    = CAM_W_DATA;
                end
            end
            CAM_W_DATA: begin
                // entry keeps its old mask until the mask commits
                s_nxt.mem_data[s_r.w_addr] = s_r.w_data;
                if (s_r.w_mask) begin
                    s_nxt.wst = CAM_W_MASK;
                end else begin
                    s_nxt.mem_care[s_r.w_addr] = CAM_CARE_ALL;
                    s_nxt.wst                  = CAM_W_IDLE;
                end
            end
            CAM_W_MASK: begin
                // mask commit ends a masked write
                s_nxt.mem_care[s_r.w_addr] = s_r.w_care;
                s_nxt.wst                  = CAM_W_IDLE;
            end
            default: begin
                s_nxt.wst = CAM_W_IDLE;
            end
        endcase
        s_nxt.w_busy = (s_nxt.wst != CAM_W_IDLE);

        // search input register; refused in the cycle after a one-hot take
        s_nxt.in_v    = srch_valid & ~s_r.s_busy;
        if (s_nxt.in_v) begin
            s_nxt.in_word = srch_word;
        end
        s_nxt.s_busy  = s_nxt.in_v & ~enc_sel;

        // result formation
        s_nxt.hi_pend = 1'b0;
        if (s_r.in_v) begin
            s_nxt.o1_v     = 1'b1;
            s_nxt.o1_match = any_hit;
            s_nxt.o1_half  = CAM_HALF_LO;
            if (enc_sel) begin
                s_nxt.o1_lines = LINES'(hit_idx) & {LINES{any_hit}};
            end else begin
                s_nxt.o1_lines = hit[LINES-1:0];
                // upper half waits one cycle
                s_nxt.hi_pend  = 1'b1;
                s_nxt.hi_vec   = hit[WORDS-1:LINES];
                s_nxt.hi_match = any_hit;
            end
        end else if (s_r.hi_pend) begin
            s_nxt.o1_v     = 1'b1;
            s_nxt.o1_match = s_r.hi_match;
            s_nxt.o1_half  = CAM_HALF_HI;
            s_nxt.o1_lines = s_r.hi_vec;
        end else begin
            s_nxt.o1_match = 1'b0;
            s_nxt.o1_lines = '0;
        end

        // optional output stage
        // only read when OUT_REG selects it
        s_nxt.o2_v     = s_r.o1_v;
        s_nxt.o2_match = s_r.o1_match;
        s_nxt.o2_half  = s_r.o1_half;
        s_nxt.o2_lines = s_r.o1_lines;

        // synchronous reset reloads the configured image
        if (rst) begin
            s_nxt = CAM_RST_IMG;
        end
    end

    // clears act at once, without the clock
    always_ff @(posedge clock or posedge clr_any) begin
        if (clr_any) begin
            s_r <= CAM_RST_IMG;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs taken from the selected stage, each straight from a flop
    assign srch_busy = s_r.s_busy;
    assign wr_busy   = s_r.w_busy;
    if (OUT_REG) begin : g_out_late
        assign res_valid = s_r.o2_v;
        assign res_match = s_r.o2_match;
        assign res_half  = s_r.o2_half;
        assign res_lines = s_r.o2_lines;
    end else begin : g_out_early
        assign res_valid = s_r.o1_v;
        assign res_match = s_r.o1_match;
        assign res_half  = s_r.o1_half;
        assign res_lines = s_r.o1_lines;
    end

endmodule // cam_core

// file: cam_props.sv
// port checker for the cam core
// assumes default parameters, OUT_REG=0
module cam_props
    import cam_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic                 clr_local,
    input wire logic                 clr_global,
    input wire logic                 clr_chip,
    input wire logic                 enc_sel,
    input wire logic                 srch_valid,
    input wire logic                 wr_en,
    input wire logic                 wr_use_mask,
    input wire logic                 srch_busy,
    input wire logic                 wr_busy,
    input wire logic                 res_valid,
    input wire logic                 res_match,
    input wire logic                 res_half,
    input wire logic [CAM_LINES-1:0] res_lines
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_wr_plain: assert property (wr_en && !wr_busy && !wr_use_mask
        |=> wr_busy ##1 !wr_busy) else $error("plain write length");
    a_wr_mask: assert property (wr_en && !wr_busy && wr_use_mask
        |=> wr_busy[*2] ##1 !wr_busy) else $error("masked write length");
    a_enc_latency: assert property (srch_valid && enc_sel
        |-> ##2 res_valid && !res_half) else $error("encoded latency");
    a_onehot_pair: assert property (srch_valid && !enc_sel && !srch_busy
        |-> ##2 res_valid && !res_half ##1 res_valid && res_half)
        else $error("one-hot halves");
    a_half_match: assert property (res_valid && res_half
        |-> res_match == $past(res_match)) else $error("halves disagree");
    a_nomatch_low: assert property (res_valid && !res_match
        |-> res_lines == '0) else $error("lines without match");
    a_idle_zero: assert property (!res_valid
        |-> res_lines == '0 && !res_match) else $error("idle result");
    a_clear_now: assert property (clr_local || clr_global || clr_chip
        |-> !res_valid && !wr_busy) else $error("clear ignored");
endmodule // cam_props
bind cam_core cam_props u_props (
    .clock       (clock),
    .rst         (rst),
    .clr_local   (clr_local),
    .clr_global  (clr_global),
    .clr_chip    (clr_chip),
    .enc_sel     (enc_sel),
    .srch_valid  (srch_valid),
    .wr_en       (wr_en),
    .wr_use_mask (wr_use_mask),
    .srch_busy   (srch_busy),
    .wr_busy     (wr_busy),
    .res_valid   (res_valid),
    .res_match   (res_match),
    .res_half    (res_half),
    .res_lines   (res_lines)
);

// file: cam_user.sv
// user-side model: writes entries, issues searches, gathers results
// assumes cam_core with OUT_REG=0; drives on falling edges
module cam_user
    import cam_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 wr_busy,
    input  wire logic                 srch_busy,
    input  wire logic                 res_valid,
    input  wire logic                 res_match,
    input  wire logic                 res_half,
    input  wire logic                 enc_sel,
    input  wire logic [CAM_LINES-1:0] res_lines,
    output logic                      srch_valid,
    output logic                      wr_en,
    output logic                      wr_use_mask,
    output logic [CAM_WIDTH-1:0]      srch_word,
    output logic [CAM_WIDTH-1:0]      wr_data,
    output logic [CAM_WIDTH-1:0]      wr_care,
    output logic [CAM_AW-1:0]         wr_addr
);
    logic [CAM_WORDS-1:0] hit;
    logic                 mt;
    logic                 bsy;
    logic [2:0]           nres;
    initial {srch_valid, wr_en, wr_use_mask, srch_word} = '0;
    initial {wr_data, wr_care, wr_addr} = '0;
    task automatic wr(input logic [CAM_AW-1:0] a,
                      input logic [CAM_WIDTH-1:0] d, c, input logic m);
        @(negedge clock);
        {wr_en, wr_addr, wr_data, wr_care, wr_use_mask} = {1'h1, a, d, c, m};
        @(negedge clock);
        {wr_en, wr_data, wr_care} = {1'h0, ~d, ~c};
        repeat (3) if (wr_busy) @(negedge clock);
    endtask
    task automatic srch(input logic [CAM_WIDTH-1:0] w);
        @(negedge clock);
        {srch_valid, srch_word} = {1'h1, w};
        @(negedge clock);
        {srch_valid, srch_word} = {1'h0, ~w};
        hit = '0;
        repeat (3) if (!res_valid) @(negedge clock);
        hit[15:0] = res_valid ? res_lines : 'x;
        mt = res_valid ? res_match : 1'hx;
        if (!enc_sel) begin
            @(negedge clock);
            hit[31:16] = res_valid && res_half ? res_lines : 'x;
        end
    endtask
    // one-hot search held into the busy cycle: the repeat must be dropped
    task automatic srch_twice(input logic [CAM_WIDTH-1:0] w);
        @(negedge clock);
        {srch_valid, srch_word} = {1'h1, w};
        @(negedge clock);
        bsy = srch_busy;
        @(negedge clock);
        {srch_valid, srch_word} = {1'h0, ~w};
        nres = 3'h0;
        repeat (4) begin
            nres = nres + {2'h0, res_valid};
            @(negedge clock);
        end
    endtask
endmodule // cam_user

// file: cam_core_tb.sv
// self-checking bench for the cam core and user model
// assumes default core parameters and a 50 MHz clock
module cam_core_tb;
    import cam_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    fail_count++; $display("CHECK FAILED %0t result mismatch", $time); end end
    logic clock, rst, enc_sel;
    logic clr_local, clr_global, clr_chip;
    logic srch_valid, wr_en, wr_use_mask, srch_busy, wr_busy;
    logic res_valid, res_match, res_half;
    logic [CAM_WIDTH-1:0] srch_word, wr_data, wr_care;
    logic [CAM_AW-1:0]    wr_addr;
    logic [CAM_LINES-1:0] res_lines;
    int                   fail_count = 0, samples_checked = 0;
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    cam_core dut (
        .clock       (clock),
        .rst         (rst),
        .clr_local   (clr_local),
        .clr_global  (clr_global),
        .clr_chip    (clr_chip),
        .enc_sel     (enc_sel),
        .srch_valid  (srch_valid),
        .srch_word   (srch_word),
        .wr_en       (wr_en),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data),
        .wr_care     (wr_care),
        .wr_use_mask (wr_use_mask),
        .srch_busy   (srch_busy),
        .wr_busy     (wr_busy),
        .res_valid   (res_valid),
        .res_match   (res_match),
        .res_half    (res_half),
        .res_lines   (res_lines)
    );
    cam_user usr (
        .clock       (clock),
        .wr_busy     (wr_busy),
        .srch_busy   (srch_busy),
        .res_valid   (res_valid),
        .res_match   (res_match),
        .res_half    (res_half),
        .enc_sel     (enc_sel),
        .res_lines   (res_lines),
        .srch_valid  (srch_valid),
        .wr_en       (wr_en),
        .wr_use_mask (wr_use_mask),
        .srch_word   (srch_word),
        .wr_data     (wr_data),
        .wr_care     (wr_care),
        .wr_addr     (wr_addr)
    );
    task automatic do_reset(input logic e);
        @(negedge clock);
        {rst, enc_sel} = {1'h1, e};
        repeat (12) @(negedge clock);
        rst = 1'h0;
    endtask
    task automatic t_onehot;
        usr.srch('0);
        `CHK(usr.hit, '1)
        usr.wr(5'h14, 32'hA5A5_0F0F, '0, 1'h0);
        usr.srch(32'hA5A5_0F0F);
        `CHK(usr.hit, 32'h0010_0000)
        usr.srch_twice(32'hA5A5_0F0F);
        `CHK(usr.bsy, 1'h1)
        `CHK(usr.nres, 3'h2)
        usr.srch('0);
        `CHK(usr.hit, 32'hFFEF_FFFF)
    endtask
    task automatic t_mask;
        usr.wr(5'h03, 32'h0000_1234, 32'hFFFF_0000, 1'h1);
        usr.srch(32'h0000_ABCD);
        `CHK(usr.mt, 1'h1)
        `CHK(usr.hit, 32'h0000_0008)
        usr.srch(32'h0001_1234);
        `CHK(usr.hit, '0)
        `CHK(usr.mt, 1'h0)
    endtask
    task automatic t_enc;
        usr.wr(5'h0C, 32'h0000_FA12, '0, 1'h0);
        usr.srch(32'h0000_FA12);
        `CHK(usr.hit, 32'h0000_000C)
    endtask
    task automatic t_clear;
        for (int k = 0; k < 3; k++) begin
            usr.wr(5'h07, 32'h0BAD_0001, '0, 1'h0);
            {clr_chip, clr_global, clr_local} = 3'h1 << k;
            @(negedge clock);
            {clr_chip, clr_global, clr_local} = 3'h0;
            usr.srch(32'h0BAD_0001);
            `CHK(usr.mt, 1'h0)
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {rst, enc_sel, clr_local, clr_global, clr_chip} = 5'h10;
        do_reset(1'h0);
        t_onehot;
        t_mask;
        do_reset(1'h1);
        t_enc;
        t_clear;
        give_verdict;
    end
    initial begin
        #20us;
        fail_count++;
        give_verdict;
    end
endmodule // cam_core_tb
